// [rtl/trfs_pkg.sv]
// Summary of operation
// - port 0 to-self frame relays only if bit set
// - port 0 broadcast relays only if bit set
// - port 0 multicast: select bit inverts CAM hit sense
// - port 0 foreign unicast: select bit inverts CAM sense
// - port 1 to-self frame relays only if bit set
// - port 1 broadcast relays only if bit set
// - port 1 multicast: select bit inverts CAM hit sense
// - port 1 foreign unicast: select bit inverts CAM sense
// - reserved bits read zero, written zero
// - all select bits reset to zero
package trfs_pkg;

    // register byte addresses
    localparam logic [3:0] ADDR_SEL_P0 = 4'h0;
    localparam logic [3:0] ADDR_SEL_P1 = 4'h4;
    localparam logic [3:0] ADDR_CTRL = 4'h8;
    localparam logic [3:0] ADDR_STAT = 4'hc;

    // select register field positions
    localparam int BIT_SELF = 11;
    localparam int BIT_BCAST = 10;
    localparam int BIT_MCAST = 9;
    localparam int BIT_FOREIGN = 8;

    // control register field positions
    localparam int BIT_EN_DIR0 = 0;
    localparam int BIT_EN_DIR1 = 1;

    // status register field positions
    localparam int BIT_ST_SLOT0 = 0;
    localparam int BIT_ST_SLOT1 = 1;
    localparam int BIT_ST_OUTV = 2;
    localparam int BIT_ST_LOCK = 3;

    // reset values
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic EN_RESET = 1'b0;

    // decision queue depth
    localparam int FIFO_DEPTH = 32;

    // destination class of a received frame
    typedef enum logic [1:0] {
        CLS_SELF,
        CLS_BCAST,
        CLS_MCAST,
        CLS_FOREIGN
    } trfs_class_t;

    // per-frame facts from a receive path
    typedef struct packed {
        logic to_self; // destination is this device
        logic bcast; // all-ones destination
        logic mcast; // group bit set
        logic cam_hit; // CAM lookup result
    } trfs_frame_t;

    // one direction's select bits
    typedef struct packed {
        logic self_relay;
        logic bcast_relay;
        logic mcast_sel;
        logic foreign_sel;
    } trfs_sel_t;

    // forwarding decision word
    typedef struct packed {
        logic src_port; // receiving port
        trfs_class_t dclass; // class found
        logic relay; // relay to the other port
    } trfs_dec_t;

    localparam int DEC_W = $bits(trfs_dec_t);

endpackage

// [rtl/trfs_top.sv]
`timescale 1ns/100ps

// decision queue with registered output stage
module trfs_fifo #(
    parameter int W = 4,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // whole queue state
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem; // storage words
        logic [AW-1:0] wr; // write pointer
        logic [AW-1:0] rd; // read pointer
        logic [CW-1:0] cnt; // words in storage
        logic in_ready; // room for one more
        logic out_valid; // output stage full
        logic [W-1:0] out_data; // output stage word
    } trfs_fifo_state_t;

    trfs_fifo_state_t s;
    trfs_fifo_state_t next_s;
    logic push;
    logic pop;

    // next-state logic
    always_comb
    begin
        next_s = s;
        push = in_valid && s.in_ready;
        pop = (s.cnt != '0) && (!s.out_valid || out_ready);
        // consumer took the output word
        if (s.out_valid && out_ready)
        begin
            next_s.out_valid = 1'b0;
        end
        // refill output stage from storage
        if (pop)
        begin
            next_s.out_data = s.mem[s.rd];
            next_s.out_valid = 1'b1;
            next_s.rd = s.rd + AW'(1);
        end
        // store incoming word
        if (push)
        begin
            next_s.mem[s.wr] = in_data;
            next_s.wr = s.wr + AW'(1);
        end
        next_s.cnt = s.cnt + CW'(push) - CW'(pop);
        // ready only while storage has room
        next_s.in_ready = (next_s.cnt < CW'(DEPTH));
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.in_ready <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign in_ready = s.in_ready;
    assign out_valid = s.out_valid;
    assign out_data = s.out_data;

endmodule // trfs_fifo

// two-port relay forwarding decision block
module trfs_top (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register bus, avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // port 0 receive path
    input wire logic rx0_valid,
    input wire trfs_pkg::trfs_frame_t rx0_frame,
    output logic rx0_ready,
    // port 1 receive path
    input wire logic rx1_valid,
    input wire trfs_pkg::trfs_frame_t rx1_frame,
    output logic rx1_ready,
    // decision stream out
    output logic dec_valid,
    output trfs_pkg::trfs_dec_t dec_data,
    input wire logic dec_ready
);

    // block state
    typedef struct packed {
        trfs_pkg::trfs_sel_t sel0; // port 0 to 1 selects
        trfs_pkg::trfs_sel_t sel1; // port 1 to 0 selects
        logic en0; // relay_enable_dir0
        logic en1; // relay_enable_dir1
        logic locked; // any relay enabled once
        logic waitreq; // bus stall
        logic [31:0] rdata; // bus read word
        trfs_pkg::trfs_dec_t slot0; // port 0 held decision
        trfs_pkg::trfs_dec_t slot1; // port 1 held decision
        logic slot0_v; // slot 0 full
        logic slot1_v; // slot 1 full
        logic rdy0; // port 0 ready
        logic rdy1; // port 1 ready
    } trfs_state_t;

    trfs_state_t s;
    trfs_state_t next_s;
    logic [1:0] rst_sync;
    logic rst_n;
    logic q_in_valid;
    trfs_pkg::trfs_dec_t q_in_data;
    logic q_in_ready;
    logic q_out_valid;
    logic bus_req;
    logic bus_go;

    // classify one frame, broadcast ahead of multicast
    function automatic trfs_pkg::trfs_class_t classify(input trfs_pkg::trfs_frame_t f);
        trfs_pkg::trfs_class_t c;
        if (f.to_self)
        begin
            c = trfs_pkg::CLS_SELF;
        end
        else if (f.bcast)
        begin
            c = trfs_pkg::CLS_BCAST;
        end
        else if (f.mcast)
        begin
            c = trfs_pkg::CLS_MCAST;
        end
        else
        begin
            c = trfs_pkg::CLS_FOREIGN;
        end
        return c;
    endfunction

    // relay decision for one frame of one direction
    function automatic trfs_pkg::trfs_dec_t decide(
        input trfs_pkg::trfs_frame_t f,
        input trfs_pkg::trfs_sel_t sel,
        input logic port,
        input logic en
    );
        trfs_pkg::trfs_dec_t d;
        logic r;
        d.src_port = port;
        d.dclass = classify(f);
        unique case (d.dclass)
            // to-self: plain gate
            trfs_pkg::CLS_SELF: r = sel.self_relay;
            // broadcast: plain gate
            trfs_pkg::CLS_BCAST: r = sel.bcast_relay;
            // multicast: hit sense flipped by select
            trfs_pkg::CLS_MCAST: r = f.cam_hit ^ sel.mcast_sel;
            // foreign unicast: hit sense flipped by select
            trfs_pkg::CLS_FOREIGN: r = f.cam_hit ^ sel.foreign_sel;
        endcase
        d.relay = r && en;
        return d;
    endfunction

    // pack select bits into a register word, reserved bits zero
    function automatic logic [31:0] sel_word(input trfs_pkg::trfs_sel_t sel);
        logic [31:0] w;
        w = 32'h0;
        w[trfs_pkg::BIT_SELF] = sel.self_relay;
        w[trfs_pkg::BIT_BCAST] = sel.bcast_relay;
        w[trfs_pkg::BIT_MCAST] = sel.mcast_sel;
        w[trfs_pkg::BIT_FOREIGN] = sel.foreign_sel;
        return w;
    endfunction

    // unpack select bits from a write word, reserved bits dropped
    function automatic trfs_pkg::trfs_sel_t sel_from(input logic [31:0] w);
        trfs_pkg::trfs_sel_t sel;
        sel.self_relay = w[trfs_pkg::BIT_SELF];
        sel.bcast_relay = w[trfs_pkg::BIT_BCAST];
        sel.mcast_sel = w[trfs_pkg::BIT_MCAST];
        sel.foreign_sel = w[trfs_pkg::BIT_FOREIGN];
        return sel;
    endfunction

    // reset release through two flops
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    // next-state logic
    always_comb
    begin
        next_s = s;
        bus_req = avs_read || avs_write;
        bus_go = bus_req && !s.waitreq;

        // bus: stall one cycle, then answer for one cycle
        if (bus_req && s.waitreq)
        begin
            next_s.waitreq = 1'b0;
            next_s.rdata = 32'h0;
            unique case (avs_address)
                trfs_pkg::ADDR_SEL_P0: next_s.rdata = sel_word(s.sel0);
                trfs_pkg::ADDR_SEL_P1: next_s.rdata = sel_word(s.sel1);
                trfs_pkg::ADDR_CTRL:
                begin
                    next_s.rdata[trfs_pkg::BIT_EN_DIR0] = s.en0;
                    next_s.rdata[trfs_pkg::BIT_EN_DIR1] = s.en1;
                end
                trfs_pkg::ADDR_STAT:
                begin
                    next_s.rdata[trfs_pkg::BIT_ST_SLOT0] = s.slot0_v;
                    next_s.rdata[trfs_pkg::BIT_ST_SLOT1] = s.slot1_v;
                    next_s.rdata[trfs_pkg::BIT_ST_OUTV] = q_out_valid;
                    next_s.rdata[trfs_pkg::BIT_ST_LOCK] = s.locked;
                end
                // unmapped: reads zero
                default: next_s.rdata = 32'h0;
            endcase
        end
        else if (bus_go)
        begin
            next_s.waitreq = 1'b1;
        end

        // writes land on the answering edge
        if (bus_go && avs_write)
        begin
            unique case (avs_address)
                trfs_pkg::ADDR_SEL_P0:
                begin
                    // selects frozen once any relay enabled
                    if (!s.locked && avs_byteenable[1])
                    begin
                        next_s.sel0 = sel_from(avs_writedata);
                    end
                end
                trfs_pkg::ADDR_SEL_P1:
                begin
                    if (!s.locked && avs_byteenable[1])
                    begin
                        next_s.sel1 = sel_from(avs_writedata);
                    end
                end
                trfs_pkg::ADDR_CTRL:
                begin
                    if (avs_byteenable[0])
                    begin
                        next_s.en0 = avs_writedata[trfs_pkg::BIT_EN_DIR0];
                        next_s.en1 = avs_writedata[trfs_pkg::BIT_EN_DIR1];
                        next_s.locked = s.locked || next_s.en0 || next_s.en1;
                    end
                end
                // status and unmapped: write ignored
                default: next_s.locked = s.locked;
            endcase
        end

        // hand one held decision to the queue, port 0 first
        q_in_valid = s.slot0_v || s.slot1_v;
        q_in_data = s.slot0_v ? s.slot0 : s.slot1;
        if (q_in_ready && s.slot0_v)
        begin
            next_s.slot0_v = 1'b0;
        end
        else if (q_in_ready && s.slot1_v)
        begin
            next_s.slot1_v = 1'b0;
        end

        // take new frames into empty slots
        if (rx0_valid && s.rdy0)
        begin
            next_s.slot0 = decide(rx0_frame, s.sel0, 1'b0, s.en0);
            next_s.slot0_v = 1'b1;
        end
        if (rx1_valid && s.rdy1)
        begin
            next_s.slot1 = decide(rx1_frame, s.sel1, 1'b1, s.en1);
            next_s.slot1_v = 1'b1;
        end
        next_s.rdy0 = !next_s.slot0_v;
        next_s.rdy1 = !next_s.slot1_v;
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.sel0 <= trfs_pkg::SEL_RESET;
            s.sel1 <= trfs_pkg::SEL_RESET;
            s.en0 <= trfs_pkg::EN_RESET;
            s.en1 <= trfs_pkg::EN_RESET;
            s.waitreq <= 1'b1;
            s.rdy0 <= 1'b1;
            s.rdy1 <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // decision queue toward the relay path
    trfs_fifo #(
        .W(trfs_pkg::DEC_W),
        .DEPTH(trfs_pkg::FIFO_DEPTH)
    ) u_queue (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(q_in_valid),
        .in_data(q_in_data),
        .in_ready(q_in_ready),
        .out_valid(q_out_valid),
        .out_data(dec_data),
        .out_ready(dec_ready)
    );

    // outputs straight from flops
    assign dec_valid = q_out_valid;
    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.waitreq;
    assign rx0_ready = s.rdy0;
    assign rx1_ready = s.rdy1;

endmodule // trfs_top

// [verif/trfs_props.sv]
`timescale 1ns/100ps

// port-level checks of the forwarding select block
module trfs_props (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // receive handshakes
    input wire logic rx0_valid,
    input wire logic rx0_ready,
    input wire logic rx1_valid,
    input wire logic rx1_ready,
    // decision stream
    input wire logic dec_valid,
    input wire trfs_pkg::trfs_dec_t dec_data,
    input wire logic dec_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // request seen while the slave still stalls
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    // one answer cycle, then stall again
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    // read answer from a select register
    sequence s_sel_read;
        avs_read && !avs_waitrequest && (avs_address == 4'h0 || avs_address == 4'h4);
    endsequence
    a_wait_answer: assert property (s_req |=> s_answer)
        else $error("bus answer not one cycle after request");
    a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("bus answered without request");
    a_sel_rsv_zero: assert property (s_sel_read |->
        avs_readdata[31:12] == 20'h0 && avs_readdata[7:0] == 8'h00)
        else $error("reserved select bits read nonzero");
    a_ctrl_rsv_zero: assert property (avs_read && !avs_waitrequest && avs_address == 4'h8
        |-> avs_readdata[31:2] == 30'h0)
        else $error("reserved control bits read nonzero");
    a_reset_quiet: assert property ($rose(arst_n) |-> (avs_waitrequest && !dec_valid)[*2])
        else $error("outputs active inside reset release");
    a_rx0_gap: assert property (rx0_valid && rx0_ready |=> !rx0_ready)
        else $error("port 0 ready not dropped after take");
    a_rx1_gap: assert property (rx1_valid && rx1_ready |=> !rx1_ready)
        else $error("port 1 ready not dropped after take");
    a_dec_hold: assert property (dec_valid && !dec_ready |=> dec_valid && $stable(dec_data))
        else $error("stalled decision changed or vanished");
endmodule // trfs_props

bind trfs_top trfs_props trfs_props_inst (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx0_valid(rx0_valid), .rx0_ready(rx0_ready), .rx1_valid(rx1_valid),
    .rx1_ready(rx1_ready), .dec_valid(dec_valid), .dec_data(dec_data), .dec_ready(dec_ready)
);

// [verif/trfs_rx_model.sv]
`timescale 1ns/100ps

// receive path stand-in: offers queued frame facts with valid and ready
module trfs_rx_model (
    // clock
    input wire logic clk,
    // handshake with the block
    input wire logic ready,
    output logic valid,
    output trfs_pkg::trfs_frame_t frame
);
    trfs_pkg::trfs_frame_t q[$]; // frames still to offer
    int taken; // frames accepted so far
    initial
    begin
        valid = 1'b0;
        frame = 4'h0;
        taken = 0;
    end
    // queue one frame for offering
    task automatic push(input trfs_pkg::trfs_frame_t f);
        q.push_back(f);
    endtask
    // hold each frame until taken; idle lines toggle so stale values never match
    always @(posedge clk)
    begin
        if (valid && ready)
        begin
            void'(q.pop_front());
            taken <= taken + 1;
        end
        valid <= (q.size() != 0);
        frame <= (q.size() != 0) ? q[0] : ~frame;
    end
endmodule // trfs_rx_model

// [verif/trfs_top_tb.sv]
`timescale 1ns/100ps

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

// bench: register tasks, two receive models, checking consumer
module trfs_top_tb;
    logic clk = 1'b0; // 25 MHz
    logic arst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic rx0_valid, rx0_ready, rx1_valid, rx1_ready;
    trfs_pkg::trfs_frame_t rx0_frame, rx1_frame;
    logic dec_valid;
    trfs_pkg::trfs_dec_t dec_data;
    logic dec_ready = 1'b0; // consumer accept
    logic drain = 1'b0; // consumer may take words
    int mismatches = 0;
    int n_compared = 0;
    trfs_pkg::trfs_dec_t eq0[$], eq1[$], e; // expected words per source port
    logic [31:0] r;
    trfs_pkg::trfs_sel_t s0, s1;
    int base, n;

    always #20 clk = ~clk;

    trfs_top trfs_top_inst (
        .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx0_valid(rx0_valid), .rx0_frame(rx0_frame), .rx0_ready(rx0_ready),
        .rx1_valid(rx1_valid), .rx1_frame(rx1_frame), .rx1_ready(rx1_ready),
        .dec_valid(dec_valid), .dec_data(dec_data), .dec_ready(dec_ready)
    );
    trfs_rx_model rx0_model (.clk(clk), .ready(rx0_ready), .valid(rx0_valid), .frame(rx0_frame));
    trfs_rx_model rx1_model (.clk(clk), .ready(rx1_ready), .valid(rx1_valid), .frame(rx1_frame));

    // one bus transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // no cycle count assumed: only the watchdog ends a wait that never answers
        do
        begin
            @(posedge clk);
        end
        while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    // decision that the rules give for one frame
    function automatic trfs_pkg::trfs_dec_t exp_dec(input logic p, input trfs_pkg::trfs_frame_t f,
        input trfs_pkg::trfs_sel_t s);
        trfs_pkg::trfs_dec_t d;
        d.src_port = p;
        d.dclass = f.to_self ? trfs_pkg::CLS_SELF : f.bcast ? trfs_pkg::CLS_BCAST :
            f.mcast ? trfs_pkg::CLS_MCAST : trfs_pkg::CLS_FOREIGN;
        case (d.dclass)
            trfs_pkg::CLS_SELF: d.relay = s.self_relay;
            trfs_pkg::CLS_BCAST: d.relay = s.bcast_relay;
            trfs_pkg::CLS_MCAST: d.relay = f.cam_hit ^ s.mcast_sel;
            default: d.relay = f.cam_hit ^ s.foreign_sel;
        endcase
        return d;
    endfunction

    // verdict and end of run
    task automatic finish_test;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // consumer: stalls, then takes every other cycle
    always @(posedge clk)
        dec_ready <= drain & ~dec_ready;

    // each taken word must match the front of its port's queue
    always @(posedge clk)
    begin
        if (dec_valid === 1'b1 && dec_ready === 1'b1)
        begin
            e = dec_data.src_port ? eq1.pop_front() : eq0.pop_front();
            `CHK(dec_data, e)
        end
    end

    // main sequence: two select patterns, each after its own reset
    initial
    begin
        for (int ph = 0; ph < 2; ph++)
        begin
            arst_n <= 1'b0;
            repeat (16) @(posedge clk);
            arst_n <= 1'b1;
            repeat (4) @(posedge clk);
            s0 = ph ? 4'h5 : 4'ha;
            s1 = ~s0;
            bus(1'b0, 4'h0, 32'h0);
            `CHK(r, 32'h0)
            bus(1'b0, 4'h4, 32'h0);
            `CHK(r, 32'h0)
            bus(1'b0, 4'h2, 32'h0);
            `CHK(r, 32'h0)
            bus(1'b1, 4'h0, {20'h0, s0, 8'h00});
            bus(1'b1, 4'h4, {20'h0, s1, 8'h00});
            bus(1'b0, 4'h0, 32'h0);
            `CHK(r, {20'h0, s0, 8'h00})
            bus(1'b0, 4'h4, 32'h0);
            `CHK(r, {20'h0, s1, 8'h00})
            bus(1'b1, 4'h8, 32'h3);
            // both enables read back, upper control bits zero
            bus(1'b0, 4'h8, 32'h0);
            `CHK(r, 32'h3)
            bus(1'b1, 4'h0, 32'h0);
            bus(1'b0, 4'h0, 32'h0);
            `CHK(r, {20'h0, s0, 8'h00})
            @(negedge clk);
            base = rx0_model.taken + rx1_model.taken;
            for (int i = 0; i < 32; i++)
            begin
                rx0_model.push(4'(i));
                eq0.push_back(exp_dec(1'b0, 4'(i), s0));
                rx1_model.push(4'(i));
                eq1.push_back(exp_dec(1'b1, 4'(i), s1));
            end
            repeat (200) @(posedge clk);
            `CHK(rx0_model.taken + rx1_model.taken - base, trfs_pkg::FIFO_DEPTH + 3)
            drain <= 1'b1;
            n = 0;
            while (eq0.size() + eq1.size() != 0 && n < 3000)
            begin
                @(posedge clk);
                n++;
            end
            `CHK(eq0.size() + eq1.size(), 0)
            drain <= 1'b0;
            repeat (4) @(posedge clk);
            // quiet block: slots and queue empty, lock still set
            bus(1'b0, 4'hc, 32'h0);
            `CHK(r, 32'h8)
        end
        finish_test;
    end

    // watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test;
    end
endmodule // trfs_top_tb
